// *** inc/adcmp_pkg.sv ***
// constants and types shared by the analog difference comparator
`default_nettype none
package adcmp_pkg;

    localparam int VAL_W    = 16;
    localparam int DIFF_W   = 17;
    localparam int IDX_W    = 4;
    localparam int ADDR_W   = 8;

    // register byte offsets
    localparam logic [7:0] OFS_GAIN   = 8'h00;
    localparam logic [7:0] OFS_OFFSET = 8'h04;
    localparam logic [7:0] OFS_ON     = 8'h08;
    localparam logic [7:0] OFS_OFF    = 8'h0C;
    localparam logic [7:0] OFS_DEC    = 8'h10;
    localparam logic [7:0] OFS_SRC    = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_DIFF   = 8'h1C;

    // source select field positions
    localparam int SRC_X_IDX   = 0;
    localparam int SRC_X_BLK   = 4;
    localparam int SRC_Y_IDX   = 8;
    localparam int SRC_Y_BLK   = 12;
    localparam int SRC_ON_IDX  = 16;
    localparam int SRC_ON_BLK  = 20;
    localparam int SRC_OFF_IDX = 24;
    localparam int SRC_OFF_BLK = 28;

    // setting ranges, gain in hundredths
    localparam int GAIN_MIN   = -1000;
    localparam int GAIN_MAX   = 1000;
    localparam int GAIN_DIV   = 100;
    localparam int OFFSET_MIN = -10000;
    localparam int OFFSET_MAX = 10000;
    localparam int THR_MIN    = -20000;
    localparam int THR_MAX    = 20000;
    localparam int DEC_MAX    = 3;
    localparam int ACT_LIM    = 32767;
    localparam int CHAN_MAX   = 1000;

    // reset values
    localparam logic signed [15:0] RST_GAIN   = 16'sh0064;
    localparam logic signed [15:0] RST_OFFSET = 16'sh0000;
    localparam logic signed [15:0] RST_ON     = 16'sh0000;
    localparam logic signed [15:0] RST_OFF    = 16'sh0000;
    localparam logic [1:0]         RST_DEC    = 2'h0;
    localparam logic [31:0]        RST_SRC    = 32'h0000_0100;

    typedef enum logic {
        ADCMP_HYST,
        ADCMP_WINDOW
    } adcmp_mode_t;

endpackage : adcmp_pkg
`default_nettype wire

// *** rtl/adcmp_scale.sv ***
// applies common gain and offset to one input value
`timescale 1ns/1ps
`default_nettype none
module adcmp_scale (
    input  wire logic signed [adcmp_pkg::VAL_W-1:0] value,
    input  wire logic signed [adcmp_pkg::VAL_W-1:0] gain,
    input  wire logic signed [adcmp_pkg::VAL_W-1:0] offset,
    output logic signed [adcmp_pkg::VAL_W-1:0]      actual
);
    logic signed [31:0] prod;
    logic signed [31:0] sum;

    always_comb begin
        // gain is held in hundredths, so the product is brought back by the divisor
        prod = 32'(value) * 32'(gain);
        sum  = prod / adcmp_pkg::GAIN_DIV + 32'(offset);
        if (sum > adcmp_pkg::ACT_LIM) begin
            actual = 16'(adcmp_pkg::ACT_LIM);
        end else if (sum < -adcmp_pkg::ACT_LIM) begin
            actual = 16'(-adcmp_pkg::ACT_LIM);
        end else begin
            actual = 16'(sum);
        end
    end
endmodule : adcmp_scale
`default_nettype wire

// *** rtl/adcmp_sel.sv ***
// picks one value from the analog channels or from another block's actual value
`timescale 1ns/1ps
`default_nettype none
module adcmp_sel #(
    parameter int NUM_CHAN = 8,
    parameter int CHAN_W   = 10,
    parameter int NUM_BLK  = 16
) (
    input  wire logic [NUM_CHAN*CHAN_W-1:0]            chan_in,
    input  wire logic [NUM_BLK*adcmp_pkg::VAL_W-1:0]   blk_in,
    input  wire logic                                  from_blk,
    input  wire logic [adcmp_pkg::IDX_W-1:0]           idx,
    output logic signed [adcmp_pkg::VAL_W-1:0]         value
);
    logic [CHAN_W-1:0] raw;

    always_comb begin
        raw   = '0;
        value = '0;
        if (from_blk) begin
            if (32'(idx) < NUM_BLK) begin
                value = blk_in[32'(idx)*adcmp_pkg::VAL_W +: adcmp_pkg::VAL_W];
            end
        end else if (32'(idx) < NUM_CHAN) begin
            raw = chan_in[32'(idx)*CHAN_W +: CHAN_W];
            // a channel spans 0..1000 for 0..10 V; overrange pins at full scale
            if (32'(raw) > adcmp_pkg::CHAN_MAX) begin
                value = 16'(adcmp_pkg::CHAN_MAX);
            end else begin
                value = 16'(raw);
            end
        end
    end
endmodule : adcmp_sel
`default_nettype wire

// *** rtl/adcmp_top.sv ***
// analog difference comparator with hysteresis and an APB register file
//
// Operation
// - each input is multiplied by common gain, then common offset added
// - difference is first actual value minus second actual value
// - on >= off: output set when difference > on, cleared when <= off
// - on < off: output high only while on <= difference < off
// - decimal places only affect display, comparisons use raw integers
// - each threshold may come from another block's actual value by number
// - a 0..10 V channel is an internal value 0..1000 before scaling
// - settings held within gain, offset, threshold and decimals ranges
//
// Implementation choices: the APB register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module adcmp_top #(
    parameter int NUM_CHAN = 8,
    parameter int CHAN_W   = 10,
    parameter int NUM_BLK  = 16
) (
    input  wire logic                                 pclk,
    input  wire logic                                 presetn,
    input  wire logic                                 psel,
    input  wire logic                                 penable,
    input  wire logic                                 pwrite,
    input  wire logic [adcmp_pkg::ADDR_W-1:0]         paddr,
    input  wire logic [31:0]                          pwdata,
    output logic [31:0]                               prdata,
    output logic                                      pready,
    output logic                                      pslverr,
    input  wire logic                                 scan_tick,
    input  wire logic [NUM_CHAN*CHAN_W-1:0]           analog_input_channels,
    input  wire logic [NUM_BLK*adcmp_pkg::VAL_W-1:0]  block_values,
    output logic                                      cmp_out
);
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic signed [15:0] on_thr;
    logic signed [15:0] off_thr;
    logic [1:0]         dec_places;
    logic [31:0]        src_sel;
    logic signed [15:0] next_gain;
    logic signed [15:0] next_offset;
    logic signed [15:0] next_on_thr;
    logic signed [15:0] next_off_thr;
    logic [1:0]         next_dec_places;
    logic [31:0]        next_src_sel;
    logic [31:0]        next_prdata;
    logic               next_pready;
    logic               next_pslverr;
    logic signed [16:0] diff;
    logic signed [16:0] next_diff;
    logic               next_cmp_out;
    logic signed [15:0] first_analog_input;
    logic signed [15:0] second_analog_input;
    logic signed [15:0] on_blk_val;
    logic signed [15:0] off_blk_val;
    logic signed [15:0] act_x;
    logic signed [15:0] act_y;
    logic signed [16:0] diff_now;
    logic signed [16:0] on_eff;
    logic signed [16:0] off_eff;
    adcmp_pkg::adcmp_mode_t mode;
    logic               wr_en;
    logic               setup;
    logic               mapped;

    // gain, offset, threshold and decimal settings are saturated into their legal span on write
    function automatic logic signed [15:0] clamp_val(input logic signed [31:0] v, input int lo, input int hi);
        logic signed [15:0] r;
        r = 16'(v);
        if (v < lo) begin
            r = 16'(lo);
        end else if (v > hi) begin
            r = 16'(hi);
        end
        return r;
    endfunction : clamp_val

    adcmp_sel #(.NUM_CHAN(NUM_CHAN), .CHAN_W(CHAN_W), .NUM_BLK(NUM_BLK)) u_sel_x (
        .chan_in  (analog_input_channels),
        .blk_in   (block_values),
        .from_blk (src_sel[adcmp_pkg::SRC_X_BLK]),
        .idx      (src_sel[adcmp_pkg::SRC_X_IDX +: adcmp_pkg::IDX_W]),
        .value    (first_analog_input)
    );

    adcmp_sel #(.NUM_CHAN(NUM_CHAN), .CHAN_W(CHAN_W), .NUM_BLK(NUM_BLK)) u_sel_y (
        .chan_in  (analog_input_channels),
        .blk_in   (block_values),
        .from_blk (src_sel[adcmp_pkg::SRC_Y_BLK]),
        .idx      (src_sel[adcmp_pkg::SRC_Y_IDX +: adcmp_pkg::IDX_W]),
        .value    (second_analog_input)
    );

    adcmp_sel #(.NUM_CHAN(NUM_CHAN), .CHAN_W(CHAN_W), .NUM_BLK(NUM_BLK)) u_sel_on (
        .chan_in  (analog_input_channels),
        .blk_in   (block_values),
        .from_blk (1'b1),
        .idx      (src_sel[adcmp_pkg::SRC_ON_IDX +: adcmp_pkg::IDX_W]),
        .value    (on_blk_val)
    );

    adcmp_sel #(.NUM_CHAN(NUM_CHAN), .CHAN_W(CHAN_W), .NUM_BLK(NUM_BLK)) u_sel_off (
        .chan_in  (analog_input_channels),
        .blk_in   (block_values),
        .from_blk (1'b1),
        .idx      (src_sel[adcmp_pkg::SRC_OFF_IDX +: adcmp_pkg::IDX_W]),
        .value    (off_blk_val)
    );

    adcmp_scale u_scale_x (
        .value  (first_analog_input),
        .gain   (gain),
        .offset (offset),
        .actual (act_x)
    );

    adcmp_scale u_scale_y (
        .value  (second_analog_input),
        .gain   (gain),
        .offset (offset),
        .actual (act_y)
    );

    // register file and APB answer, zero wait states
    always_comb begin
        setup  = psel && !penable;
        wr_en  = psel && penable && pready && pwrite;
        mapped = (paddr[1:0] == 2'h0) && (paddr <= adcmp_pkg::OFS_DIFF);
        next_gain       = gain;
        next_offset     = offset;
        next_on_thr     = on_thr;
        next_off_thr    = off_thr;
        next_dec_places = dec_places;
        next_src_sel    = src_sel;
        next_pready     = setup;
        next_pslverr    = setup && !mapped;
        next_prdata     = prdata;
        if (wr_en) begin
            unique case (paddr)
                adcmp_pkg::OFS_GAIN:   next_gain =
                    clamp_val(pwdata, adcmp_pkg::GAIN_MIN, adcmp_pkg::GAIN_MAX);
                adcmp_pkg::OFS_OFFSET: next_offset =
                    clamp_val(pwdata, adcmp_pkg::OFFSET_MIN, adcmp_pkg::OFFSET_MAX);
                adcmp_pkg::OFS_ON:     next_on_thr =
                    clamp_val(pwdata, adcmp_pkg::THR_MIN, adcmp_pkg::THR_MAX);
                adcmp_pkg::OFS_OFF:    next_off_thr =
                    clamp_val(pwdata, adcmp_pkg::THR_MIN, adcmp_pkg::THR_MAX);
                adcmp_pkg::OFS_DEC:    next_dec_places = 2'(clamp_val(pwdata, 0, adcmp_pkg::DEC_MAX));
                adcmp_pkg::OFS_SRC:    next_src_sel = pwdata;
                default:               next_src_sel = src_sel;
            endcase
        end
        if (setup) begin
            unique case (paddr)
                adcmp_pkg::OFS_GAIN:   next_prdata = 32'(gain);
                adcmp_pkg::OFS_OFFSET: next_prdata = 32'(offset);
                adcmp_pkg::OFS_ON:     next_prdata = 32'(on_thr);
                adcmp_pkg::OFS_OFF:    next_prdata = 32'(off_thr);
                adcmp_pkg::OFS_DEC:    next_prdata = {30'h0, dec_places};
                adcmp_pkg::OFS_SRC:    next_prdata = src_sel;
                adcmp_pkg::OFS_STATUS: next_prdata = {30'h0, mode == adcmp_pkg::ADCMP_WINDOW, cmp_out};
                adcmp_pkg::OFS_DIFF:   next_prdata = 32'(diff);
                default:               next_prdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gain       <= adcmp_pkg::RST_GAIN;
            offset     <= adcmp_pkg::RST_OFFSET;
            on_thr     <= adcmp_pkg::RST_ON;
            off_thr    <= adcmp_pkg::RST_OFF;
            dec_places <= adcmp_pkg::RST_DEC;
            src_sel    <= adcmp_pkg::RST_SRC;
            prdata     <= 32'h0000_0000;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
        end else begin
            gain       <= next_gain;
            offset     <= next_offset;
            on_thr     <= next_on_thr;
            off_thr    <= next_off_thr;
            dec_places <= next_dec_places;
            src_sel    <= next_src_sel;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
        end
    end

    // comparison, evaluated once per scan
    always_comb begin
        diff_now = 17'(act_x) - 17'(act_y);
        // dec_places never reaches this path: thresholds compare as raw integers
        on_eff  = src_sel[adcmp_pkg::SRC_ON_BLK] ? 17'(on_blk_val) : 17'(on_thr);
        off_eff = src_sel[adcmp_pkg::SRC_OFF_BLK] ? 17'(off_blk_val) : 17'(off_thr);
        mode    = (on_eff >= off_eff) ? adcmp_pkg::ADCMP_HYST : adcmp_pkg::ADCMP_WINDOW;
        next_diff    = diff;
        next_cmp_out = cmp_out;
        if (scan_tick) begin
            next_diff = diff_now;
            unique case (mode)
                adcmp_pkg::ADCMP_HYST: begin
                    if (diff_now > on_eff) begin
                        next_cmp_out = 1'b1;
                    end else if (diff_now <= off_eff) begin
                        next_cmp_out = 1'b0;
                    end else begin
                        next_cmp_out = cmp_out;
                    end
                end
                adcmp_pkg::ADCMP_WINDOW: begin
                    next_cmp_out = (diff_now >= on_eff) && (diff_now < off_eff);
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            diff    <= 17'h00000;
            cmp_out <= 1'b0;
        end else begin
            diff    <= next_diff;
            cmp_out <= next_cmp_out;
        end
    end

    // checks
    sequence s_scan_hyst;
        scan_tick && (on_eff >= off_eff);
    endsequence

    sequence s_scan_window;
        scan_tick && (on_eff < off_eff);
    endsequence

    AST_UNITY_SCALE: assert property (@(posedge pclk) disable iff (!presetn)
        (gain == 16'sh0064 && offset == 16'sh0000) |-> act_x == first_analog_input)
        else $error("unity gain changed the first input");

    AST_DIFF_TRACK: assert property (@(posedge pclk) disable iff (!presetn)
        scan_tick |=> diff == $past(17'(act_x) - 17'(act_y)))
        else $error("stored difference is not x minus y");

    AST_HYST_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (s_scan_hyst and (scan_tick && diff_now > on_eff)) |=> cmp_out)
        else $error("output not set above on threshold");

    AST_HYST_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (s_scan_hyst and (scan_tick && diff_now <= off_eff)) |=> !cmp_out)
        else $error("output not cleared at or below off threshold");

    AST_WINDOW_OUT: assert property (@(posedge pclk) disable iff (!presetn)
        s_scan_window |=> cmp_out == ($past(diff_now) >= $past(on_eff) && $past(diff_now) < $past(off_eff)))
        else $error("window output wrong");

    AST_HOLD_BAND: assert property (@(posedge pclk) disable iff (!presetn)
        (s_scan_hyst and (scan_tick && diff_now <= on_eff && diff_now > off_eff)) |=> $stable(cmp_out))
        else $error("output moved inside hysteresis band");

    AST_NO_SCAN_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        !scan_tick |=> $stable(cmp_out) && $stable(diff))
        else $error("output changed without a scan");

    AST_THR_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        src_sel[adcmp_pkg::SRC_ON_BLK] |-> on_eff == 17'(on_blk_val))
        else $error("on threshold not taken from block");

    AST_CHAN_SPAN: assert property (@(posedge pclk) disable iff (!presetn)
        !src_sel[adcmp_pkg::SRC_X_BLK] |-> first_analog_input >= 16'sh0000 && first_analog_input <= adcmp_pkg::CHAN_MAX)
        else $error("channel value outside 0..1000");

    AST_RANGES: assert property (@(posedge pclk) disable iff (!presetn)
        gain >= adcmp_pkg::GAIN_MIN && gain <= adcmp_pkg::GAIN_MAX && dec_places <= 2'h3
        && offset >= adcmp_pkg::OFFSET_MIN && offset <= adcmp_pkg::OFFSET_MAX
        && on_thr >= adcmp_pkg::THR_MIN && on_thr <= adcmp_pkg::THR_MAX && off_thr >= adcmp_pkg::THR_MIN
        && off_thr <= adcmp_pkg::THR_MAX)
        else $error("setting outside its range");

    AST_DEC_IGNORED: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == adcmp_pkg::OFS_DEC && !scan_tick) |=> $stable(cmp_out))
        else $error("decimal setting disturbed the output");

    AST_APB_ANSWER: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // an error flag without the answer would be missed by the master
    AST_APB_ERR: assert property (@(posedge pclk) disable iff (!presetn)
        pslverr |-> pready)
        else $error("error flag without answer");

    AST_SAT_GAIN: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_en && paddr == adcmp_pkg::OFS_GAIN && signed'(pwdata) > adcmp_pkg::GAIN_MAX) |=> gain == adcmp_pkg::GAIN_MAX)
        else $error("gain not saturated at its maximum");

    AST_OFF_BLOCK: assert property (@(posedge pclk) disable iff (!presetn)
        src_sel[adcmp_pkg::SRC_OFF_BLK] |-> off_eff == 17'(off_blk_val))
        else $error("off threshold not taken from block");

    AST_SAT_SCALE: assert property (@(posedge pclk) disable iff (!presetn)
        act_y >= -adcmp_pkg::ACT_LIM && act_y <= adcmp_pkg::ACT_LIM)
        else $error("scaled value beyond its limit");

endmodule : adcmp_top
`default_nettype wire

// *** sim/adcmp_src_model.sv ***
// behavioural far side: analog channels and actual values of other blocks
`timescale 1ns/1ps
`default_nettype none
module adcmp_src_model (
    input  wire logic        pclk,
    input  wire logic        ld,
    input  wire logic        to_blk,
    input  wire logic [3:0]  idx,
    input  wire logic [15:0] val,
    output logic [79:0]      chan,
    output logic [255:0]     blk
);
    initial begin
        chan = '0;
        blk  = '0;
    end
    // a source holds its level between loads, like a settled sensor
    always @(posedge pclk) begin
        if (ld && to_blk) begin
            blk[idx*16 +: 16] <= val;
        end else if (ld && idx < 4'h8) begin
            chan[idx*10 +: 10] <= val[9:0];
        end
    end
endmodule : adcmp_src_model
`default_nettype wire

// *** sim/analog_difference_comparator_tb.sv ***
// self-checking bench for the analog difference comparator
`timescale 1ns/1ps
`default_nettype none
module analog_difference_comparator_tb;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scan_tick = 1'b0;
    logic        cmp_out;
    logic [79:0] chans;
    logic [255:0] blks;
    logic        ld = 1'b0;
    logic        to_blk = 1'b0;
    logic [3:0]  idx = 4'h0;
    logic [15:0] val = 16'h0;
    int          n_errors = 0;
    int          num_checks = 0;
    logic [31:0] st = 32'hA25C;
    logic [31:0] rd;
    logic        err;
    logic [31:0] src = 32'h100;
    logic        q = 1'b0;
    int          chan_m[8];
    int          blk_m[16];
    int          gain = 100, ofs = 0, on_t = 0, off_t = 0, dif = 0;

    always #50 pclk = ~pclk;

    adcmp_src_model u_src (.pclk(pclk), .ld(ld), .to_blk(to_blk), .idx(idx), .val(val), .chan(chans), .blk(blks));

    adcmp_top #(.NUM_CHAN(8), .CHAN_W(10), .NUM_BLK(16)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_tick(scan_tick), .analog_input_channels(chans), .block_values(blks), .cmp_out(cmp_out));

    task automatic print_verdict;
        if (n_errors == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    function automatic int rr(input int lo, input int hi);
        st = {st[30:0], st[31] ^ st[21] ^ st[1] ^ st[0]};
        return lo + int'(st % (hi - lo + 1));
    endfunction : rr

    function automatic int sat(input int v, input int lo, input int hi);
        return v > hi ? hi : (v < lo ? lo : v);
    endfunction : sat

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            n_errors++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic set_reg(input logic [7:0] a, input int v);
        apb(1'b1, a, v);
        case (a)
            adcmp_pkg::OFS_GAIN:   gain = sat(v, adcmp_pkg::GAIN_MIN, adcmp_pkg::GAIN_MAX);
            adcmp_pkg::OFS_OFFSET: ofs = sat(v, adcmp_pkg::OFFSET_MIN, adcmp_pkg::OFFSET_MAX);
            adcmp_pkg::OFS_ON:     on_t = sat(v, adcmp_pkg::THR_MIN, adcmp_pkg::THR_MAX);
            adcmp_pkg::OFS_OFF:    off_t = sat(v, adcmp_pkg::THR_MIN, adcmp_pkg::THR_MAX);
            adcmp_pkg::OFS_SRC:    src = v;
            default: ;
        endcase
    endtask : set_reg

    task automatic put(input logic b, input logic [3:0] i, input int v);
        @(posedge pclk);
        ld <= 1'b1;
        to_blk <= b;
        idx <= i;
        val <= v[15:0];
        @(posedge pclk);
        ld <= 1'b0;
        if (b) begin
            blk_m[i] = v;
        end else if (i < 8) begin
            chan_m[i] = v;
        end
    endtask : put

    function automatic int pick(input logic b, input logic [3:0] i);
        if (b) begin
            return blk_m[i];
        end
        if (i > 4'h7) begin
            return 0;
        end
        return chan_m[i] > adcmp_pkg::CHAN_MAX ? adcmp_pkg::CHAN_MAX : chan_m[i];
    endfunction : pick

    function automatic int scl(input int v);
        return sat(v * gain / adcmp_pkg::GAIN_DIV + ofs, -adcmp_pkg::ACT_LIM, adcmp_pkg::ACT_LIM);
    endfunction : scl

    // model result first, then one scan pulse, then the three observable results
    task automatic scan_chk;
        int on_v, off_v;
        on_v = src[20] ? blk_m[src[19:16]] : on_t;
        off_v = src[28] ? blk_m[src[27:24]] : off_t;
        dif = scl(pick(src[4], src[3:0])) - scl(pick(src[12], src[11:8]));
        if (on_v >= off_v) begin
            if (dif > on_v) begin
                q = 1'b1;
            end else if (dif <= off_v) begin
                q = 1'b0;
            end
        end else begin
            q = (dif >= on_v && dif < off_v);
        end
        @(posedge pclk);
        scan_tick <= 1'b1;
        @(posedge pclk);
        scan_tick <= 1'b0;
        @(posedge pclk);
        check({31'h0, cmp_out}, {31'h0, q});
        apb(1'b0, adcmp_pkg::OFS_DIFF, 32'h0);
        check(rd, dif);
        apb(1'b0, adcmp_pkg::OFS_STATUS, 32'h0);
        check({31'h0, rd[0]}, {31'h0, q});
        if (!src[20] && !src[28]) begin
            check({31'h0, rd[1]}, {31'h0, on_v < off_v});
        end
    endtask : scan_chk

    logic [7:0]  ra[8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C};
    logic [31:0] rv[8] = '{32'h64, 32'h0, 32'h0, 32'h0, 32'h0, 32'h100, 32'h0, 32'h0};
    int          hd[10] = '{11, 0, -5, 0, 10, -5, 9, 10, -6, 0};

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check(rd, rv[i]);
        end
        // unmapped, unaligned and read-only places
        apb(1'b0, 8'h20, 32'h0);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
        apb(1'b1, 8'h02, 32'h5);
        check({31'h0, err}, 32'h1);
        apb(1'b1, adcmp_pkg::OFS_DIFF, 32'hFFFF_FFFF);
        apb(1'b0, adcmp_pkg::OFS_DIFF, 32'h0);
        check(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            set_reg(ra[i], (i % 2) ? -40000 : 40000);
            apb(1'b0, ra[i], 32'h0);
            check(rd, i == 0 ? gain : i == 1 ? ofs : i == 2 ? on_t : i == 3 ? off_t : 3);
        end
        set_reg(adcmp_pkg::OFS_GAIN, 100);
        set_reg(adcmp_pkg::OFS_OFFSET, 0);
        put(1'b0, 4'h1, 500);
        // hysteresis band first, then window band, edges of each
        for (int i = 0; i < 10; i++) begin
            if (i == 0 || i == 5) begin
                set_reg(adcmp_pkg::OFS_ON, i == 0 ? 10 : -5);
                set_reg(adcmp_pkg::OFS_OFF, i == 0 ? -5 : 10);
            end
            put(1'b0, 4'h0, 500 + hd[i]);
            scan_chk();
        end
        for (int n = 0; n < 30; n++) begin
            for (int i = 0; i < 8; i++) begin
                put(1'b0, i[3:0], rr(0, 1023));
            end
            for (int i = 0; i < 16; i++) begin
                put(1'b1, i[3:0], rr(-20000, 20000));
            end
            set_reg(adcmp_pkg::OFS_GAIN, rr(-1000, 1000));
            set_reg(adcmp_pkg::OFS_OFFSET, rr(-10000, 10000));
            set_reg(adcmp_pkg::OFS_ON, rr(-20000, 20000));
            set_reg(adcmp_pkg::OFS_OFF, rr(-20000, 20000));
            set_reg(adcmp_pkg::OFS_DEC, rr(0, 3));
            set_reg(adcmp_pkg::OFS_SRC, rr(0, 1) ? (st & 32'h1F1F_1F1F) : (st & 32'h0F1F_0F1F));
            scan_chk();
        end
        print_verdict();
    end
endmodule : analog_difference_comparator_tb
`default_nettype wire
